// File: rtl/dcb_pkg.sv
package dcb_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [15:0] ADDR_VF_GAIN       = 16'h123f;
    localparam logic [15:0] ADDR_VBOOST_M1     = 16'h1240;
    localparam logic [15:0] ADDR_SBOOST_M1     = 16'h1241;
    localparam logic [15:0] ADDR_BRK_MODE      = 16'h1245;
    localparam logic [15:0] ADDR_BRK_TRIG      = 16'h1246;
    localparam logic [15:0] ADDR_BRK_WAIT      = 16'h1247;
    localparam logic [15:0] ADDR_BRK_DFORCE    = 16'h1248;
    localparam logic [15:0] ADDR_BRK_DTIME     = 16'h1249;
    localparam logic [15:0] ADDR_BRK_DETECT    = 16'h124a;
    localparam logic [15:0] ADDR_BRK_SFORCE    = 16'h124b;
    localparam logic [15:0] ADDR_BRK_STIME     = 16'h124c;
    localparam logic [15:0] ADDR_BRK_CARRIER   = 16'h124d;
    localparam logic [15:0] ADDR_RSVD_124E     = 16'h124e;
    localparam logic [15:0] ADDR_UPPER_HI      = 16'h124f;
    localparam logic [15:0] ADDR_UPPER_LO      = 16'h1250;
    localparam logic [15:0] ADDR_VBOOST_M2     = 16'h2240;
    localparam logic [15:0] ADDR_SBOOST_M2     = 16'h2241;

    // ==========================================================
    // Legal ranges
    localparam logic [15:0] VF_GAIN_MIN        = 16'h0014; // 20
    localparam logic [15:0] VF_GAIN_MAX        = 16'h00c8; // 200
    localparam logic [15:0] BOOST_MAX          = 16'h00ff; // 255
    localparam logic [15:0] BRK_MODE_MAX       = 16'h0002;
    localparam logic [15:0] FREQ_MAX           = 16'h9c40; // 40000
    localparam logic [15:0] FREQ_LIMIT_MIN     = 16'h0032; // 50
    localparam logic [15:0] BRK_WAIT_MAX       = 16'h0032; // 50
    localparam logic [15:0] BRK_FORCE_MAX      = 16'h0050; // 80
    localparam logic [15:0] BRK_TIME_MAX       = 16'h0258; // 600
    localparam logic [15:0] BRK_DETECT_MAX     = 16'h0001;
    localparam logic [15:0] CARRIER_MIN        = 16'h0005; // 5
    localparam logic [15:0] CARRIER_MAX_SMALL  = 16'h0096; // 150
    localparam logic [15:0] CARRIER_MAX_LARGE  = 16'h0064; // 100

    // ==========================================================
    // Values after reset
    localparam logic [7:0]  RST_VF_GAIN        = 8'h64;
    localparam logic [7:0]  RST_BOOST          = 8'h64;
    localparam logic [7:0]  RST_CARRIER        = 8'h32;

    // ==========================================================
    // Field codes
    localparam logic [1:0]  BRK_MODE_OFF       = 2'h0;
    localparam logic [1:0]  BRK_MODE_ON        = 2'h1;
    localparam logic [1:0]  BRK_MODE_FREQ      = 2'h2;
    localparam logic        DETECT_EDGE        = 1'b0;
    localparam logic        DETECT_LEVEL       = 1'b1;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam int unsigned BRK_TICK_NS        = 100_000_000; // 0.1 s
    localparam int unsigned BRK_TICK_CYCLES    = BRK_TICK_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_BRAKE = 4'b1000
    } dcb_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } dcb_bus_req_t;

    typedef struct packed {
        logic       active;
        logic       startHold;
        logic [7:0] brkForce;
        logic [7:0] carrier;
    } dcb_brake_out_t;

endpackage

// File: rtl/dcb_param_bank.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dcb_param_bank
    import dcb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = BRK_TICK_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire dcb_bus_req_t   busReq,
    output logic [15:0]         rdData,
    input  wire logic           largeModel,
    input  wire logic [15:0]    maximumFreq,
    input  wire logic [15:0]    outFreq,
    input  wire logic           decelerating,
    input  wire logic           startReq,
    input  wire logic           externalBrakeInput,
    output dcb_brake_out_t      brakeOut,
    output logic [15:0]         upperFreqLimit,
    output logic [7:0]          vfGain,
    output logic [7:0]          voltageBoostGain1,
    output logic [7:0]          slipBoostGain1,
    output logic [7:0]          voltageBoostGain2,
    output logic [7:0]          slipBoostGain2
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  vfGain;
        logic [7:0]  vBoost1;
        logic [7:0]  sBoost1;
        logic [7:0]  vBoost2;
        logic [7:0]  sBoost2;
        logic [1:0]  brkMode;
        logic [15:0] brkTrig;
        logic [5:0]  brkWait;
        logic [6:0]  brkDForce;
        logic [9:0]  brkDTime;
        logic        brkDetect;
        logic [6:0]  brkSForce;
        logic [9:0]  brkSTime;
        logic [7:0]  carrier;
        logic [15:0] upperHi;
        logic [15:0] upperLo;
        logic [15:0] rdData;
        dcb_state_t  state;
        logic [19:0] tickCnt;
        logic [9:0]  timer;
        logic        extPrev;
        logic        armed;
        logic        levelRun;
        dcb_brake_out_t out;
    } dcb_bank_t;

    dcb_bank_t st_q;
    dcb_bank_t st_d;

    // ==========================================================
    // Helpers
    function automatic logic inRange(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
        inRange = (v >= lo) && (v <= hi);
    endfunction

    // Zero, or 50..40000 and below the maximum frequency
    function automatic logic limitOk(input logic [31:0] v, input logic [15:0] maxF);
        logic ok;
        ok = 1'b0;
        if (v == 32'h0000_0000) begin
            ok = 1'b1;
        end else if (v[31:16] == 16'h0000) begin
            ok = inRange(v[15:0], FREQ_LIMIT_MIN, FREQ_MAX) && (v[15:0] < maxF);
        end
        limitOk = ok;
    endfunction

    function automatic logic [15:0] readReg(input dcb_bank_t s, input logic [15:0] a);
        logic [15:0] r;
        r = 16'h0000;
        unique case (a)
            ADDR_VF_GAIN:     r = {8'h00, s.vfGain};
            ADDR_VBOOST_M1:   r = {8'h00, s.vBoost1};
            ADDR_SBOOST_M1:   r = {8'h00, s.sBoost1};
            ADDR_VBOOST_M2:   r = {8'h00, s.vBoost2};
            ADDR_SBOOST_M2:   r = {8'h00, s.sBoost2};
            ADDR_BRK_MODE:    r = {14'h0000, s.brkMode};
            ADDR_BRK_TRIG:    r = s.brkTrig;
            ADDR_BRK_WAIT:    r = {10'h000, s.brkWait};
            ADDR_BRK_DFORCE:  r = {9'h000, s.brkDForce};
            ADDR_BRK_DTIME:   r = {6'h00, s.brkDTime};
            ADDR_BRK_DETECT:  r = {15'h0000, s.brkDetect};
            ADDR_BRK_SFORCE:  r = {9'h000, s.brkSForce};
            ADDR_BRK_STIME:   r = {6'h00, s.brkSTime};
            ADDR_BRK_CARRIER: r = {8'h00, s.carrier};
            ADDR_UPPER_HI:    r = s.upperHi;
            ADDR_UPPER_LO:    r = s.upperLo;
            default:          r = 16'h0000;
        endcase
        readReg = r;
    endfunction

    // ==========================================================
    // Next state
    logic [15:0] wv;
    logic        wr;
    logic        tick;
    logic        extRise;
    logic        extHit;
    logic        freqHit;
    logic [15:0] carrierMax;
    logic        timeUp;

    always_comb begin
        st_d       = st_q;
        wv         = busReq.wdata;
        wr         = busReq.wr;
        carrierMax = largeModel ? CARRIER_MAX_LARGE : CARRIER_MAX_SMALL;
        tick       = (st_q.tickCnt == 20'(TICK_CYCLES - 1));
        extRise    = externalBrakeInput && !st_q.extPrev;
        timeUp     = 1'b0;

        // Read data stands only in the cycle after the strobe
        st_d.rdData = busReq.rd ? readReg(st_q, busReq.addr) : 16'h0000;

        // Writes, each checked against its range
        if (wr) begin
            unique case (busReq.addr)
                ADDR_VF_GAIN: begin
                    if (inRange(wv, VF_GAIN_MIN, VF_GAIN_MAX)) st_d.vfGain = wv[7:0];
                end
                ADDR_VBOOST_M1: begin
                    if (wv <= BOOST_MAX) st_d.vBoost1 = wv[7:0];
                end
                ADDR_VBOOST_M2: begin
                    if (wv <= BOOST_MAX) st_d.vBoost2 = wv[7:0];
                end
                ADDR_SBOOST_M1: begin
                    if (wv <= BOOST_MAX) st_d.sBoost1 = wv[7:0];
                end
                ADDR_SBOOST_M2: begin
                    if (wv <= BOOST_MAX) st_d.sBoost2 = wv[7:0];
                end
                ADDR_BRK_MODE: begin
                    if (wv <= BRK_MODE_MAX) st_d.brkMode = wv[1:0];
                end
                ADDR_BRK_TRIG: begin
                    if (wv <= FREQ_MAX) st_d.brkTrig = wv;
                end
                ADDR_BRK_WAIT: begin
                    if (wv <= BRK_WAIT_MAX) st_d.brkWait = wv[5:0];
                end
                ADDR_BRK_DFORCE: begin
                    if (wv <= BRK_FORCE_MAX) st_d.brkDForce = wv[6:0];
                end
                ADDR_BRK_DTIME: begin
                    if (wv <= BRK_TIME_MAX) st_d.brkDTime = wv[9:0];
                end
                ADDR_BRK_DETECT: begin
                    if (wv <= BRK_DETECT_MAX) st_d.brkDetect = wv[0];
                end
                ADDR_BRK_SFORCE: begin
                    if (wv <= BRK_FORCE_MAX) st_d.brkSForce = wv[6:0];
                end
                ADDR_BRK_STIME: begin
                    if (wv <= BRK_TIME_MAX) st_d.brkSTime = wv[9:0];
                end
                ADDR_BRK_CARRIER: begin
                    if (inRange(wv, CARRIER_MIN, carrierMax)) st_d.carrier = wv[7:0];
                end
                ADDR_UPPER_HI: begin
                    if (limitOk({wv, st_q.upperLo}, maximumFreq)) st_d.upperHi = wv;
                end
                ADDR_UPPER_LO: begin
                    if (limitOk({st_q.upperHi, wv}, maximumFreq)) st_d.upperLo = wv;
                end
                default: begin
                    st_d.rdData = st_d.rdData;
                end
            endcase
        end

        // Trigger sources for the braking sequence
        extHit  = (st_q.brkMode == BRK_MODE_ON) &&
                  ((st_q.brkDetect == DETECT_EDGE) ? extRise : externalBrakeInput);
        freqHit = st_q.armed && (outFreq <= st_q.brkTrig) &&
                  ((st_q.brkMode == BRK_MODE_FREQ) ||
                   ((st_q.brkMode == BRK_MODE_ON) && decelerating));
        if (outFreq > st_q.brkTrig) begin
            st_d.armed = 1'b1;
        end
        st_d.extPrev = externalBrakeInput;

        // 0.1 s time base and tick counter
        st_d.tickCnt = tick ? 20'h00000 : st_q.tickCnt + 20'h00001;
        if (tick) begin
            st_d.timer = st_q.timer + 10'h001;
        end

        // Braking sequence
        unique case (st_q.state)
            ST_IDLE: begin
                if (startReq && (st_q.brkMode != BRK_MODE_OFF) &&
                    (st_q.brkSTime != 10'h000)) begin
                    st_d.state = ST_START;
                end else if (freqHit || extHit) begin
                    st_d.state    = ST_WAIT;
                    st_d.armed    = 1'b0;
                    st_d.levelRun = extHit && (st_q.brkDetect == DETECT_LEVEL);
                end
            end
            ST_START: begin
                timeUp = (st_q.timer >= st_q.brkSTime);
                if (timeUp || (st_q.brkMode == BRK_MODE_OFF)) begin
                    st_d.state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (st_q.levelRun && !externalBrakeInput) begin
                    st_d.state = ST_IDLE;
                end else if (st_q.timer >= {4'h0, st_q.brkWait}) begin
                    st_d.state = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                if (st_q.levelRun) begin
                    timeUp = !externalBrakeInput;
                end else begin
                    timeUp = (st_q.timer >= st_q.brkDTime);
                end
                if (timeUp || (st_q.brkMode == BRK_MODE_OFF)) begin
                    st_d.state    = ST_IDLE;
                    st_d.levelRun = 1'b0;
                end
            end
        endcase

        // Timing restarts on every change of state
        if (st_d.state != st_q.state) begin
            st_d.tickCnt = 20'h00000;
            st_d.timer   = 10'h000;
        end

        // Power stage commands
        st_d.out.active    = (st_d.state == ST_START) || (st_d.state == ST_BRAKE);
        st_d.out.startHold = (st_d.state == ST_START);
        st_d.out.carrier   = st_d.carrier;
        unique case (st_d.state)
            ST_START: st_d.out.brkForce = {1'b0, st_d.brkSForce};
            ST_BRAKE: st_d.out.brkForce = {1'b0, st_d.brkDForce};
            default:  st_d.out.brkForce = 8'h00;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q           <= '0;
            st_q.vfGain    <= RST_VF_GAIN;
            st_q.vBoost1   <= RST_BOOST;
            st_q.sBoost1   <= RST_BOOST;
            st_q.vBoost2   <= RST_BOOST;
            st_q.sBoost2   <= RST_BOOST;
            st_q.carrier   <= RST_CARRIER;
            st_q.brkMode   <= BRK_MODE_OFF;
            st_q.state     <= ST_IDLE;
            st_q.out.carrier <= RST_CARRIER;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign rdData            = st_q.rdData;
    assign brakeOut          = st_q.out;
    assign upperFreqLimit    = st_q.upperLo; // High word always zero when legal
    assign vfGain            = st_q.vfGain;
    assign voltageBoostGain1 = st_q.vBoost1;
    assign slipBoostGain1    = st_q.sBoost1;
    assign voltageBoostGain2 = st_q.vBoost2;
    assign slipBoostGain2    = st_q.sBoost2;

endmodule

`default_nettype wire

// File: test/dcb_param_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register bank property checker
module dcb_param_bank_sva
    import dcb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = BRK_TICK_CYCLES
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire dcb_bus_req_t   busReq,
    input wire logic [15:0]    rdData,
    input wire dcb_brake_out_t brakeOut,
    input wire logic [15:0]    upperFreqLimit,
    input wire logic [7:0]     vfGain
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Decoded gain writes
    wire logic vfWr = busReq.wr && busReq.addr == ADDR_VF_GAIN;
    wire logic vfOk = busReq.wdata >= VF_GAIN_MIN && busReq.wdata <= VF_GAIN_MAX;

    a_rd_idle_zero: assert property (!busReq.rd |=> rdData == 16'h0)
        else $error("read data not zero outside answer cycle");
    a_rsvd_read_zero: assert property (busReq.rd && busReq.addr == ADDR_RSVD_124E
        |=> rdData == 16'h0) else $error("reserved word read not zero");
    a_upper_hi_zero: assert property (busReq.rd && busReq.addr == ADDR_UPPER_HI
        |=> rdData == 16'h0) else $error("upper limit high word not zero");
    a_vf_write_taken: assert property (vfWr && vfOk
        |=> vfGain == $past(busReq.wdata[7:0])) else $error("legal gain write lost");
    a_vf_bad_kept: assert property (vfWr && !vfOk |=> $stable(vfGain))
        else $error("illegal gain write stored");
    a_mode_read_back: assert property (busReq.wr && busReq.addr == ADDR_BRK_MODE
        && busReq.wdata <= BRK_MODE_MAX ##1 !busReq.wr
        ##1 busReq.rd && busReq.addr == ADDR_BRK_MODE
        |=> rdData == $past(busReq.wdata, 3)) else $error("mode read back wrong");
    a_force_cap: assert property (brakeOut.brkForce <= BRK_FORCE_MAX[7:0])
        else $error("brake force above limit");
    a_idle_no_force: assert property (!brakeOut.active |-> brakeOut.brkForce == 8'h0)
        else $error("force while not braking");
    a_start_is_active: assert property (brakeOut.startHold |-> brakeOut.active)
        else $error("start hold without braking");
    a_carrier_range: assert property (brakeOut.carrier >= CARRIER_MIN[7:0]
        && brakeOut.carrier <= CARRIER_MAX_SMALL[7:0]) else $error("carrier out of range");
    a_limit_range: assert property (upperFreqLimit == 16'h0
        || (upperFreqLimit >= FREQ_LIMIT_MIN && upperFreqLimit <= FREQ_MAX))
        else $error("upper limit out of range");

    c_start: cover property ($rose(brakeOut.startHold));
    c_decel: cover property ($rose(brakeOut.active) && !brakeOut.startHold);
    c_rsvd: cover property (busReq.rd && busReq.addr == ADDR_RSVD_124E);
endmodule

bind dcb_param_bank dcb_param_bank_sva #(.TICK_CYCLES(TICK_CYCLES)) dcb_param_bank_sva_i (
    .clk(clk),
    .rst(rst),
    .busReq(busReq),
    .rdData(rdData),
    .brakeOut(brakeOut),
    .upperFreqLimit(upperFreqLimit),
    .vfGain(vfGain)
);
`default_nettype wire

// File: test/dcb_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Network master on the register port
module dcb_master_model
    import dcb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] rdData,
    output var dcb_bus_req_t busReq
);
    // Bus idle from time zero
    initial busReq = '0;

    // One write, strobe high for one edge
    task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
    endtask

    // One read, data taken in the answer cycle
    task automatic rdReg(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1 d = rdData;
    endtask
endmodule
`default_nettype wire

// File: test/dcb_param_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcb_param_bank_tb
    import dcb_pkg::*;
;
    localparam int unsigned TK = 4;
    // ==========================================
    // Bench signals
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           largeModel = 1'b0;
    logic           decelerating = 1'b0;
    logic           startReq = 1'b0;
    logic           externalBrakeInput = 1'b0;
    logic [15:0]    maximumFreq = 16'h03e8;
    logic [15:0]    outFreq = 16'h0000;
    logic [15:0]    rdData;
    logic [15:0]    upperFreqLimit;
    logic [7:0]     vfGain;
    logic [7:0]     vBoost1;
    logic [7:0]     sBoost1;
    logic [7:0]     vBoost2;
    logic [7:0]     sBoost2;
    dcb_bus_req_t   busReq;
    dcb_brake_out_t brakeOut;
    int             errorCnt = 0;
    int             nTests = 0;
    int             cycles = 0;

    always #50 clk = ~clk;

    dcb_param_bank #(.TICK_CYCLES(TK)) dcb_param_bank_i (
        .clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
        .largeModel(largeModel), .maximumFreq(maximumFreq), .outFreq(outFreq),
        .decelerating(decelerating), .startReq(startReq),
        .externalBrakeInput(externalBrakeInput), .brakeOut(brakeOut),
        .upperFreqLimit(upperFreqLimit), .vfGain(vfGain), .voltageBoostGain1(vBoost1),
        .slipBoostGain1(sBoost1), .voltageBoostGain2(vBoost2), .slipBoostGain2(sBoost2)
    );
    dcb_master_model dcb_master_model_i (.clk(clk), .rdData(rdData), .busReq(busReq));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        dcb_master_model_i.wrReg(a, d);
    endtask
    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        dcb_master_model_i.rdReg(a, d);
        chk(d, exp);
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic waitAct(input logic lvl, output int n);
        for (n = 0; n < 60 && brakeOut.active !== lvl; n++)
            tick();
    endtask

    task automatic tReset;
        rdChk(ADDR_VF_GAIN, 16'h0064);
        rdChk(ADDR_BRK_CARRIER, 16'h0032);
        rdChk(ADDR_BRK_MODE, 16'h0000);
        rdChk(16'h1242, 16'h0000);
    endtask
    task automatic tRanges;
        logic [15:0] ad [14] = '{ADDR_VF_GAIN, ADDR_VBOOST_M1, ADDR_SBOOST_M1,
            ADDR_VBOOST_M2, ADDR_SBOOST_M2, ADDR_BRK_MODE, ADDR_BRK_TRIG, ADDR_BRK_WAIT,
            ADDR_BRK_DFORCE, ADDR_BRK_DTIME, ADDR_BRK_DETECT, ADDR_BRK_SFORCE,
            ADDR_BRK_STIME, ADDR_BRK_CARRIER};
        logic [15:0] mx [14] = '{VF_GAIN_MAX, BOOST_MAX, BOOST_MAX, BOOST_MAX, BOOST_MAX,
            BRK_MODE_MAX, FREQ_MAX, BRK_WAIT_MAX, BRK_FORCE_MAX, BRK_TIME_MAX,
            BRK_DETECT_MAX, BRK_FORCE_MAX, BRK_TIME_MAX, CARRIER_MAX_SMALL};
        for (int i = 0; i < 14; i++) begin
            wr(ad[i], mx[i]);
            rdChk(ad[i], mx[i]);
            wr(ad[i], mx[i] + 16'h1);
            rdChk(ad[i], mx[i]);
        end
        wr(ADDR_VF_GAIN, VF_GAIN_MIN - 16'h1);
        rdChk(ADDR_VF_GAIN, VF_GAIN_MAX);
        wr(ADDR_VF_GAIN, VF_GAIN_MIN);
        #1;
        chk({8'h0, vfGain}, VF_GAIN_MIN);
        wr(ADDR_BRK_CARRIER, CARRIER_MIN - 16'h1);
        rdChk(ADDR_BRK_CARRIER, CARRIER_MAX_SMALL);
        @(posedge clk) largeModel <= 1'b1;
        wr(ADDR_BRK_CARRIER, CARRIER_MAX_LARGE + 16'h1);
        rdChk(ADDR_BRK_CARRIER, CARRIER_MAX_SMALL);
        wr(ADDR_BRK_CARRIER, CARRIER_MAX_LARGE);
        rdChk(ADDR_BRK_CARRIER, CARRIER_MAX_LARGE);
        chk({8'h0, vBoost1}, BOOST_MAX);
        chk({8'h0, vBoost2}, BOOST_MAX);
        chk({8'h0, sBoost1}, BOOST_MAX);
        chk({8'h0, sBoost2}, BOOST_MAX);
    endtask
    task automatic tUpper;
        wr(ADDR_UPPER_LO, 16'h03e7);
        #1;
        chk(upperFreqLimit, 16'h03e7);
        wr(ADDR_UPPER_LO, 16'h03e8);
        wr(ADDR_UPPER_LO, FREQ_LIMIT_MIN - 16'h1);
        wr(ADDR_UPPER_HI, 16'h0001);
        rdChk(ADDR_UPPER_LO, 16'h03e7);
        rdChk(ADDR_UPPER_HI, 16'h0000);
        wr(ADDR_UPPER_LO, 16'h0000);
        rdChk(ADDR_UPPER_LO, 16'h0000);
        wr(ADDR_RSVD_124E, 16'h00ff);
        rdChk(ADDR_RSVD_124E, 16'h0000);
    endtask
    task automatic tEdge;
        int n;
        wr(ADDR_BRK_WAIT, 16'h0001);
        wr(ADDR_BRK_DTIME, 16'h0002);
        wr(ADDR_BRK_DFORCE, 16'h001e);
        wr(ADDR_BRK_DETECT, 16'h0000);
        wr(ADDR_BRK_MODE, 16'h0001);
        @(posedge clk) externalBrakeInput <= 1'b1;
        waitAct(1'b1, n);
        chk(16'(n > TK && n <= TK + 4), 16'h1);
        chk({8'h0, brakeOut.brkForce}, 16'h001e);
        waitAct(1'b0, n);
        chk(16'(n), 16'(2 * TK + 1));
    endtask
    task automatic tLevel;
        @(posedge clk) externalBrakeInput <= 1'b0;
        wr(ADDR_BRK_WAIT, 16'h0000);
        wr(ADDR_BRK_DETECT, 16'h0001);
        @(posedge clk) externalBrakeInput <= 1'b1;
        repeat (4 * TK) tick();
        chk({15'h0, brakeOut.active}, 16'h1);
        @(posedge clk) externalBrakeInput <= 1'b0;
        repeat (3) tick();
        chk({15'h0, brakeOut.active}, 16'h0);
    endtask
    task automatic tStart;
        int n;
        wr(ADDR_BRK_SFORCE, 16'h0014);
        wr(ADDR_BRK_STIME, 16'h0001);
        @(posedge clk) startReq <= 1'b1;
        @(posedge clk) startReq <= 1'b0;
        #1;
        waitAct(1'b1, n);
        chk({15'h0, brakeOut.startHold}, 16'h1);
        chk({8'h0, brakeOut.brkForce}, 16'h0014);
        waitAct(1'b0, n);
        chk(16'(n), 16'(TK + 1));
        wr(ADDR_BRK_MODE, 16'h0000);
        @(posedge clk) startReq <= 1'b1;
        externalBrakeInput <= 1'b1;
        @(posedge clk) startReq <= 1'b0;
        repeat (3 * TK) tick();
        chk({15'h0, brakeOut.active}, 16'h0);
        @(posedge clk) externalBrakeInput <= 1'b0;
    endtask
    task automatic tFreq;
        int n;
        wr(ADDR_BRK_TRIG, 16'h03e8);
        wr(ADDR_BRK_MODE, 16'h0002);
        @(posedge clk) outFreq <= 16'h07d0;
        repeat (3) @(posedge clk);
        chk({15'h0, brakeOut.active}, 16'h0);
        outFreq <= 16'h03e8;
        waitAct(1'b1, n);
        chk(16'(n <= 4), 16'h1);
        chk({8'h0, brakeOut.brkForce}, 16'h001e);
        waitAct(1'b0, n);
    endtask

    // Main sequence after the reset period
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tReset();
        tRanges();
        tUpper();
        tEdge();
        tLevel();
        tStart();
        tFreq();
        printVerdict();
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errorCnt++;
            printVerdict();
        end
    end
endmodule
`default_nettype wire
